// ### sas_sequencer.sv
`timescale 1ns/1ps
`include "sas_map.svh"
// Notes on behaviour
// - Each sample is resolved by successive approximation into ten bits.
// - Single mode converts the selected channel once into its own data register.
// - Conversion starts whenever go becomes one, from software, timers or pin.
// - Single-mode completion sets end flag; interrupt raised if enabled.
// - Go reads one during single conversion, hardware clears it at end.
// - Clearing go mid-conversion in single or single-cycle scan aborts to idle.
// - Scan modes cover up to eight channels, lowest first, ascending.
// - Each scan result goes to its channel register before the next channel.
// - Continuous scan sets flag after last channel and restarts immediately.
// - Continuous scan repeats while go is one; clearing go stops it.
// - Single-cycle scan converts each channel once, sets flag, clears go.
// - Sampling waits a start delay that depends on the write's clock phase.
// - Two-bit clock select gives 1024, 512, 256 or 128 states.
// - Only the first scan conversion uses single timing; later ones are shorter.
// - Enabled timer requests set go and start like a software write.
// - Source 00 or 01 lets a pin falling edge set go.
// - Routed to transfer controller: no interrupt; transfer clears the flag.
// - Module starts in standby; registers usable only after standby is cleared.
// - Mode field: 00 single, 01 four-channel scan, 10 eight-channel scan.
// - Data registers hold result in bits 15..6, low bits zero, reset zero.
// - Reading a data register loads its lower byte into a temporary register.
// - End flag clears by writing zero after reading it as one, or when a routed transfer completes.
module sas_sequencer #(
  parameter int ADDR_W = 8,
  parameter int NUM_CH = `SAS_NUM_CH,
  parameter int RES_BITS = `SAS_RES_BITS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trigger_pin,
  input wire logic multifunction_timer_req,
  input wire logic motor_mgmt_timer_req,
  input wire logic transfer_controller_done,
  input wire logic cmp_in,
  output logic [9:0] sar_code,
  output logic [2:0] ch_sel,
  output logic sample_hold,
  output logic conv_end_irq,
  output logic xfer_req
);

  if (NUM_CH != `SAS_NUM_CH || RES_BITS != `SAS_RES_BITS || ADDR_W < 8) begin : g_chk
    $error("sas_sequencer: unsupported channel count, resolution or address width");
  end

  sas_pkg::sas_regs_t q, n;

  logic [6:0] step;
  logic phase0;
  logic fall;
  logic fset;
  logic setup;
  logic acc;
  logic ok;
  logic [7:0] off;
  logic [2:0] didx;
  logic is_data;
  logic [31:0] rv;
  logic [2:0] first_ch;
  logic [2:0] last_ch;
  logic [9:0] fc;
  logic [9:0] smp;
  logic [9:0] smp_scan;

  always_comb begin
    n = q;
    fset = 1'b0;
    step = 7'((`SAS_CONV_STATES / `SAS_STEPS_PER_CONV) >> q.cks);
    phase0 = ((q.presc & 6'(step - 7'd1)) == 6'h00);
    n.presc = q.presc + 6'h01;

    // Pin inputs: a change counts once the second and third stages agree
    n.trg_s = {q.trg_s[1:0], ext_trigger_pin};
    n.cmp_s = {q.cmp_s[1:0], cmp_in};
    if (q.trg_s[1] == q.trg_s[2]) begin
      n.trg_f = q.trg_s[2];
    end
    if (q.cmp_s[1] == q.cmp_s[2]) begin
      n.cmp_f = q.cmp_s[2];
    end
    fall = q.trg_f & (q.trg_s[2:1] == 2'b00);

    // Register bus: answer registered in setup, presented during access
    setup = psel & ~penable;
    acc = psel & penable & q.pready;
    off = paddr[7:0];
    is_data = (off[7:5] == 3'b001) && (off[1:0] == 2'b00);
    didx = off[4:2];
    ok = 1'b1;
    rv = 32'h0000_0000;
    if (is_data) begin
      rv[`SAS_DATA_LSB +: 10] = q.data[didx];
    end else begin
      case (off)
        `SAS_OFF_CSR: begin
          rv[`SAS_CSR_FLAG] = q.flag;
          rv[`SAS_CSR_IE] = q.ie;
          rv[`SAS_CSR_MODE +: 2] = q.mode;
          rv[`SAS_CSR_ONE] = 1'b1;
          rv[`SAS_CSR_CH +: 3] = q.ch;
        end
        `SAS_OFF_CR: begin
          rv[`SAS_CR_GO] = q.go;
          rv[`SAS_CR_CKS +: 2] = q.cks;
          rv[`SAS_CR_CYC] = q.cyc;
        end
        `SAS_OFF_TSR: rv[`SAS_TSR_SRC +: 2] = q.src;
        `SAS_OFF_STBY: rv[0] = q.stby;
        `SAS_OFF_ROUTE: rv[0] = q.route;
        `SAS_OFF_TEMP: rv[7:0] = q.temp;
        default: ok = 1'b0;
      endcase
    end
    if (q.stby && off != `SAS_OFF_STBY) begin
      ok = 1'b0;
    end
    if (paddr[ADDR_W-1:0] != ADDR_W'(off)) begin
      ok = 1'b0;
    end
    n.pready = setup;
    n.pslverr = setup & ~ok;
    n.prdata = (setup && ok) ? rv : 32'h0000_0000;

    if (acc && ok && !pwrite) begin
      if (is_data) begin
        n.temp = {q.data[didx][1:0], 6'h00};
      end else if (off == `SAS_OFF_CSR && q.flag) begin
        n.seen = 1'b1;
      end
    end
    if (acc && ok && pwrite) begin
      case (off)
        `SAS_OFF_CSR: begin
          if (!pwdata[`SAS_CSR_FLAG] && q.seen) begin
            n.flag = 1'b0;
            n.seen = 1'b0;
          end
          n.ie = pwdata[`SAS_CSR_IE];
          n.mode = pwdata[`SAS_CSR_MODE +: 2];
          n.ch = pwdata[`SAS_CSR_CH +: 3];
        end
        `SAS_OFF_CR: begin
          n.go = pwdata[`SAS_CR_GO];
          n.cks = pwdata[`SAS_CR_CKS +: 2];
          n.cyc = pwdata[`SAS_CR_CYC];
        end
        `SAS_OFF_TSR: n.src = pwdata[`SAS_TSR_SRC +: 2];
        `SAS_OFF_STBY: n.stby = pwdata[0];
        `SAS_OFF_ROUTE: n.route = pwdata[0];
        default: n.stby = q.stby;
      endcase
    end

    // Hardware start sources
    if (!q.src[1] && fall) begin
      n.go = 1'b1;
    end
    if ((q.src == sas_pkg::SAS_SRC_MFT && multifunction_timer_req) ||
        (q.src == sas_pkg::SAS_SRC_MMT && motor_mgmt_timer_req)) begin
      n.go = 1'b1;
    end

    // Channel group
    case (q.mode)
      sas_pkg::SAS_MODE_SCAN4: begin
        first_ch = {q.ch[2], 2'b00};
        last_ch = q.ch;
      end
      sas_pkg::SAS_MODE_SCAN8: begin
        first_ch = 3'd0;
        last_ch = {q.ch[1:0], 1'b1};
      end
      default: begin
        first_ch = q.ch;
        last_ch = q.ch;
      end
    endcase

    fc = q.code;
    fc[q.bi] = q.cmp_f;
    // Products of up to 320 states need nine bits, more than step holds, so widen before multiplying
    smp_scan = 10'(step) * 10'(`SAS_SAMPLE_STEPS_SCAN) - 10'h001;
    smp = q.first ? 10'(step) * 10'(`SAS_SAMPLE_STEPS_FIRST) - 10'h001 : smp_scan;

    case (q.st)
      sas_pkg::SAS_IDLE: begin
        n.sh = 1'b0;
        if (n.go) begin
          n.cur = first_ch;
          n.first = 1'b1;
          n.st = sas_pkg::SAS_WAIT;
        end
      end
      sas_pkg::SAS_WAIT: begin
        // Start delay: wait for the next step boundary of the free prescaler
        if (phase0) begin
          n.st = sas_pkg::SAS_SAMPLE;
          n.cnt = smp;
          n.sh = 1'b1;
        end
      end
      sas_pkg::SAS_SAMPLE: begin
        if (q.cnt == 10'h000) begin
          n.st = sas_pkg::SAS_CONV;
          n.sh = 1'b0;
          n.code = `SAS_CODE_MID;
          n.bi = 4'd9;
          n.cnt = 10'(step - 7'd1);
        end else begin
          n.cnt = q.cnt - 10'h001;
        end
      end
      sas_pkg::SAS_CONV: begin
        if (q.cnt != 10'h000) begin
          n.cnt = q.cnt - 10'h001;
        end else if (q.bi != 4'd0) begin
          n.code = fc;
          n.code[q.bi - 4'd1] = 1'b1;
          n.bi = q.bi - 4'd1;
          n.cnt = 10'(step - 7'd1);
        end else begin
          n.code = fc;
          n.data[q.cur] = fc;
          if (q.mode == sas_pkg::SAS_MODE_SINGLE) begin
            fset = 1'b1;
            n.go = 1'b0;
            n.st = sas_pkg::SAS_IDLE;
          end else if (q.cur == last_ch) begin
            fset = 1'b1;
            if (q.cyc) begin
              n.go = 1'b0;
              n.st = sas_pkg::SAS_IDLE;
            end else begin
              n.cur = first_ch;
              n.first = 1'b0;
              n.st = sas_pkg::SAS_SAMPLE;
              n.cnt = smp_scan;
              n.sh = 1'b1;
            end
          end else begin
            n.cur = q.cur + 3'd1;
            n.first = 1'b0;
            n.st = sas_pkg::SAS_SAMPLE;
            n.cnt = smp_scan;
            n.sh = 1'b1;
          end
        end
      end
      default: n.st = sas_pkg::SAS_IDLE;
    endcase

    // Go cleared by software stops any mode at once
    if (!n.go && q.st != sas_pkg::SAS_IDLE) begin
      n.st = sas_pkg::SAS_IDLE;
      n.sh = 1'b0;
    end
    if (n.stby) begin
      n.go = 1'b0;
      n.st = sas_pkg::SAS_IDLE;
      n.sh = 1'b0;
    end

    if (q.route && transfer_controller_done) begin
      n.flag = 1'b0;
      n.seen = 1'b0;
    end
    // A completion in the clearing cycle still leaves the flag set
    if (fset) begin
      n.flag = 1'b1;
    end
    n.irq = n.flag & n.ie & ~n.route;
    n.xreq = n.flag & n.ie & n.route;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.st <= sas_pkg::SAS_IDLE;
      q.stby <= `SAS_STBY_RST;
      q.data <= {`SAS_NUM_CH{`SAS_DATA_RST}};
      q.trg_s <= 3'b111;
      q.trg_f <= 1'b1;
    end else if (clk_en) begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign sar_code = q.code;
  assign ch_sel = q.cur;
  assign sample_hold = q.sh;
  assign conv_end_irq = q.irq;
  assign xfer_req = q.xreq;

endmodule // sas_sequencer

// ### sas_map.svh
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// Register offsets (byte addresses on APB)
`define SAS_OFF_CSR 8'h00
`define SAS_OFF_CR 8'h04
`define SAS_OFF_TSR 8'h08
`define SAS_OFF_STBY 8'h0c
`define SAS_OFF_ROUTE 8'h10
`define SAS_OFF_TEMP 8'h14
`define SAS_OFF_DATA 8'h20

// Control/status field positions
`define SAS_CSR_FLAG 7
`define SAS_CSR_IE 6
`define SAS_CSR_MODE 4
`define SAS_CSR_ONE 3
`define SAS_CSR_CH 0
`define SAS_CR_GO 0
`define SAS_CR_CKS 1
`define SAS_CR_CYC 3
`define SAS_TSR_SRC 0
`define SAS_DATA_LSB 6

// Reset values and starting trial code
`define SAS_STBY_RST 1'b1
`define SAS_DATA_RST 10'h000
`define SAS_CODE_MID 10'h200

// Sizes and timing counts, in peripheral-clock states or in steps of a conversion
`define SAS_RES_BITS 10
`define SAS_NUM_CH 8
`define SAS_CONV_STATES 1024
`define SAS_STEPS_PER_CONV 16
`define SAS_SAMPLE_STEPS_FIRST 5
`define SAS_SAMPLE_STEPS_SCAN 4

`endif

// ### sas_pkg.sv
package sas_pkg;

  typedef enum logic [3:0] {
    SAS_IDLE = 4'b0001,
    SAS_WAIT = 4'b0010,
    SAS_SAMPLE = 4'b0100,
    SAS_CONV = 4'b1000
  } sas_state_t;

  typedef enum logic [1:0] {
    SAS_MODE_SINGLE = 2'b00,
    SAS_MODE_SCAN4 = 2'b01,
    SAS_MODE_SCAN8 = 2'b10
  } sas_mode_t;

  typedef enum logic [1:0] {
    SAS_SRC_EXT0 = 2'b00,
    SAS_SRC_EXT1 = 2'b01,
    SAS_SRC_MFT = 2'b10,
    SAS_SRC_MMT = 2'b11
  } sas_src_t;

  typedef struct packed {
    sas_state_t st;
    logic go;
    logic ie;
    logic [1:0] mode;
    logic [2:0] ch;
    logic [1:0] cks;
    logic cyc;
    logic [1:0] src;
    logic route;
    logic stby;
    logic flag;
    logic seen;
    logic [7:0] temp;
    logic [7:0][9:0] data;
    logic [2:0] cur;
    logic first;
    logic [9:0] cnt;
    logic [3:0] bi;
    logic [9:0] code;
    logic [5:0] presc;
    logic [2:0] trg_s;
    logic trg_f;
    logic [2:0] cmp_s;
    logic cmp_f;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic xreq;
    logic sh;
  } sas_regs_t;

endpackage

// ### sas_analog_model.sv
`timescale 1ns/1ps
module sas_analog_model (
  input wire logic sys_clk,
  input wire logic [7:0][9:0] level,
  input wire logic [2:0] ch_sel,
  input wire logic [9:0] sar_code,
  output logic cmp_in
);
  initial cmp_in = 1'b0;
  // Registered, so the answer lags the trial code like a real comparator
  always @(posedge sys_clk) begin
    cmp_in <= (level[ch_sel] >= sar_code);
  end
endmodule // sas_analog_model

// ### sas_sequencer_chk.sv
`timescale 1ns/1ps
`include "sas_map.svh"
module sas_sequencer_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] ch_sel,
  input wire logic sample_hold,
  input wire logic conv_end_irq,
  input wire logic xfer_req
);
  default clocking cb @(posedge sys_clk); endclocking
  // A frozen design answers nothing, so checking pauses with it
  default disable iff (rst || !clk_en);
  logic stby_r;
  logic [9:0] sh_len_r;
  logic wr_ok;
  assign wr_ok = clk_en && psel && penable && pready && pwrite && !pslverr;
  // Shadow of standby so refusals can be judged from the ports alone
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stby_r <= 1'b1;
    end else if (wr_ok && paddr == ADDR_W'(`SAS_OFF_STBY)) begin
      stby_r <= pwdata[0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || !sample_hold) begin
      sh_len_r <= 10'h000;
    end else if (clk_en) begin
      sh_len_r <= sh_len_r + 10'h001;
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> answer_s)
    else $error("no single-cycle answer after setup");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  standby_refuse_a: assert property (
    stby_r && psel && !penable && paddr != ADDR_W'(`SAS_OFF_STBY) |=> pslverr)
    else $error("access in standby not refused");
  standby_idle_a: assert property (stby_r |-> !sample_hold)
    else $error("sampling in standby");
  data_low_zero_a: assert property (
    pready && !pwrite && !pslverr && paddr >= ADDR_W'(`SAS_OFF_DATA)
    |-> prdata[5:0] == 6'h00 && prdata[31:16] == 16'h0000)
    else $error("data word outside bits 15..6");
  route_excl_a: assert property (!(conv_end_irq && xfer_req))
    else $error("request sent both ways");
  irq_hold_a: assert property (conv_end_irq && !psel && !$past(psel) |=> conv_end_irq)
    else $error("interrupt dropped without cause");
  ie_clear_a: assert property (
    wr_ok && paddr == ADDR_W'(`SAS_OFF_CSR) && !pwdata[`SAS_CSR_IE]
    |=> ##1 !conv_end_irq && !xfer_req)
    else $error("request stands with enable clear");
  ch_hold_a: assert property (sample_hold && $past(sample_hold) |-> $stable(ch_sel))
    else $error("channel moved while sampling");
  // A stop written by software may cut sampling short, so those falls are excused
  sample_len_a: assert property (
    $fell(sample_hold) && !$past(wr_ok) && !$past(wr_ok, 2)
    |-> sh_len_r inside {10'd32, 10'd40, 10'd64, 10'd80, 10'd128, 10'd160, 10'd256, 10'd320})
    else $error("sampling length off");
endmodule // sas_sequencer_chk
bind sas_sequencer sas_sequencer_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk), .rst(rst),
  .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_sel(ch_sel),
  .sample_hold(sample_hold), .conv_end_irq(conv_end_irq), .xfer_req(xfer_req));

// ### tb_sar_adc_sequencer.sv
`timescale 1ns/1ps
`include "sas_map.svh"
module tb_sar_adc_sequencer;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pin = 1'b1;
  logic mft = 1'b0;
  logic motor_mgmt_timer = 1'b0;
  logic tcd = 1'b0;
  logic en = 1'b1;
  logic cmp_in;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] sar_code;
  logic [2:0] ch_sel;
  logic sh;
  logic irq;
  logic xreq;
  logic [7:0][9:0] lvl;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 32'h1f69bc4f;
  always #5 sys_clk = ~sys_clk;
  sas_sequencer dut (.sys_clk(sys_clk), .rst(rst), .clk_en(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_trigger_pin(pin),
    .multifunction_timer_req(mft), .motor_mgmt_timer_req(motor_mgmt_timer),
    .transfer_controller_done(tcd), .cmp_in(cmp_in), .sar_code(sar_code),
    .ch_sel(ch_sel), .sample_hold(sh), .conv_end_irq(irq), .xfer_req(xreq));
  sas_analog_model ana (.sys_clk(sys_clk), .level(lvl), .ch_sel(ch_sel),
    .sar_code(sar_code), .cmp_in(cmp_in));
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic hang(input string what);
    chk(what, 32'h1, 32'h0);
    final_report();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) hang("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(input logic x, input logic v);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while ((x ? xreq : irq) !== v && k < 4000);
    if ((x ? xreq : irq) !== v) hang("request level");
  endtask
  function automatic logic [31:0] dexp(input logic [9:0] v);
    return {16'h0000, v, 6'h00};
  endfunction
  // Flag written 0, interrupt enable 1, reserved bit 1
  function automatic logic [31:0] csr(input logic [1:0] m, input logic [2:0] c);
    return {24'h0, 2'b01, m, 1'b1, c};
  endfunction
  task automatic data(input logic [2:0] c, input logic [9:0] v);
    apb(1'b0, 8'(`SAS_OFF_DATA + 4 * c), 32'h0);
    chk("data", dexp(v), rd);
    apb(1'b0, `SAS_OFF_TEMP, 32'h0);
    chk("temp", {24'h0, v[1:0], 6'h00}, rd);
  endtask
  task automatic clear(input logic [31:0] w);
    apb(1'b1, `SAS_OFF_CSR, w);
    repeat (2) @(posedge sys_clk);
    chk("flag kept", 32'h1, {31'h0, irq});
    apb(1'b0, `SAS_OFF_CSR, 32'h0);
    chk("flag", 32'h1, {31'h0, rd[7]});
    apb(1'b1, `SAS_OFF_CSR, w);
    wt(1'b0, 1'b0);
  endtask
  initial begin
    int i;
    logic [2:0] c;
    logic [9:0] keep;
    for (i = 0; i < 8; i++) lvl[i] = 10'($random(seed));
    lvl[0] = 10'h3ff;
    lvl[7] = 10'h000;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, `SAS_OFF_CSR, 32'h0);
    chk("standby", 32'h1, {31'h0, err});
    apb(1'b1, `SAS_OFF_STBY, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    data(3'd5, 10'h000);
    $display("test standby done");
    for (i = 0; i < 3; i++) begin
      c = (i == 0) ? 3'd0 : (i == 1) ? 3'd7 : 3'($random(seed));
      apb(1'b1, `SAS_OFF_CSR, csr(2'b00, c));
      apb(1'b1, `SAS_OFF_CR, 32'(2 * i + 3));
      apb(1'b0, `SAS_OFF_CR, 32'h0);
      chk("go busy", 32'h1, {31'h0, rd[0]});
      wt(1'b0, 1'b1);
      data(c, lvl[c]);
      apb(1'b0, `SAS_OFF_CR, 32'h0);
      chk("go done", 32'h0, {31'h0, rd[0]});
      clear(csr(2'b00, c));
    end
    $display("test single done");
    for (i = 0; i < 8; i++) lvl[i] = 10'($random(seed));
    apb(1'b1, `SAS_OFF_CR, 32'h6);
    apb(1'b1, `SAS_OFF_CSR, csr(2'b10, 3'd3));
    apb(1'b1, `SAS_OFF_CR, 32'hf);
    wt(1'b0, 1'b1);
    for (i = 0; i < 8; i++) data(3'(i), lvl[i]);
    apb(1'b0, `SAS_OFF_CR, 32'h0);
    chk("go cleared", 32'h0, {31'h0, rd[0]});
    clear(csr(2'b10, 3'd3));
    $display("test scan8 done");
    keep = lvl[7];
    for (i = 0; i < 8; i++) lvl[i] = 10'($random(seed));
    apb(1'b1, `SAS_OFF_ROUTE, 32'h1);
    apb(1'b1, `SAS_OFF_CSR, csr(2'b01, 3'd6));
    apb(1'b1, `SAS_OFF_CR, 32'h7);
    wt(1'b1, 1'b1);
    chk("cpu irq", 32'h0, {31'h0, irq});
    for (i = 4; i < 7; i++) data(3'(i), lvl[i]);
    data(3'd7, keep);
    @(posedge sys_clk) tcd <= 1'b1;
    @(posedge sys_clk) tcd <= 1'b0;
    wt(1'b1, 1'b0);
    wt(1'b1, 1'b1);
    apb(1'b1, `SAS_OFF_CR, 32'h6);
    @(posedge sys_clk) tcd <= 1'b1;
    @(posedge sys_clk) tcd <= 1'b0;
    wt(1'b1, 1'b0);
    repeat (600) @(posedge sys_clk);
    chk("stopped", 32'h0, {31'h0, xreq | sh});
    apb(1'b1, `SAS_OFF_ROUTE, 32'h0);
    $display("test scan4 done");
    apb(1'b1, `SAS_OFF_CSR, csr(2'b00, 3'd2));
    for (i = 0; i < 4; i++) begin
      lvl[2] = 10'($random(seed));
      apb(1'b1, `SAS_OFF_TSR, 32'(i));
      @(posedge sys_clk);
      pin <= (i > 1);
      mft <= (i == 2);
      motor_mgmt_timer <= (i == 3);
      @(posedge sys_clk);
      mft <= 1'b0;
      motor_mgmt_timer <= 1'b0;
      repeat (4) @(posedge sys_clk);
      pin <= 1'b1;
      wt(1'b0, 1'b1);
      data(3'd2, lvl[2]);
      clear(csr(2'b00, 3'd2));
    end
    $display("test trigger done");
    // Past the longest start delay plus sampling, so the stop lands mid-conversion
    apb(1'b1, `SAS_OFF_CR, 32'h1);
    repeat (390) @(posedge sys_clk);
    // Frozen longer than one step, so a running design would have moved its trial code
    en <= 1'b0;
    @(posedge sys_clk) keep = sar_code;
    repeat (100) @(posedge sys_clk);
    chk("frozen", {22'h0, keep}, {22'h0, sar_code});
    en <= 1'b1;
    repeat (10) @(posedge sys_clk);
    apb(1'b1, `SAS_OFF_CR, 32'h0);
    repeat (1200) @(posedge sys_clk);
    chk("abort", 32'h0, {31'h0, irq | sh});
    $display("test abort done");
    final_report();
  end
endmodule // tb_sar_adc_sequencer
